/* File: pkg/tpw_pkg.sv */
// Shared constants and types for the two-channel timer and PWM block.
package tpw_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [3:0] IDX_SC = 4'h0;
  localparam logic [3:0] IDX_CNT_HI = 4'h1;
  localparam logic [3:0] IDX_CNT_LO = 4'h2;
  localparam logic [3:0] IDX_MOD_HI = 4'h3;
  localparam logic [3:0] IDX_MOD_LO = 4'h4;
  localparam logic [3:0] IDX_CH0_SC = 4'h5;
  localparam logic [3:0] IDX_CH0_HI = 4'h6;
  localparam logic [3:0] IDX_CH0_LO = 4'h7;
  localparam logic [3:0] IDX_CH1_SC = 4'h8;
  localparam logic [3:0] IDX_CH1_HI = 4'h9;
  localparam logic [3:0] IDX_CH1_LO = 4'ha;
  localparam logic [3:0] IDX_SOPT = 4'hb;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int SC_OVF_BIT = 7;
  localparam int SC_OVF_IE_BIT = 6;
  localparam int SC_CENTER_BIT = 5;
  localparam int SC_CLK_HI = 4;
  localparam int SC_CLK_LO = 3;
  localparam int SC_PS_HI = 2;
  localparam int CH_FLAG_BIT = 7;
  localparam int CH_IE_BIT = 6;
  localparam int CH_MODE_HI = 5;
  localparam int CH_MODE_LO = 4;
  localparam int CH_EDGE_HI = 3;
  localparam int CH_EDGE_LO = 2;
  localparam int SOPT_SLOW_OSC_BIT = 0;
  localparam int SOPT_PIN0_BIT = 1;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_UNUSED = 2'h2;
  localparam logic [1:0] CLK_XTAL = 2'h3;
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] SOPT_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] MOD_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [6:0] PRE_RESET = 7'h00;

  typedef enum logic {TPW_UP = 1'b0, TPW_DOWN = 1'b1} tpw_dir_type;

endpackage : tpw_pkg

/* File: core/tpw_channel.sv */
// One timer channel: capture, compare and PWM with its own control register.
`timescale 1ns/1ps
`default_nettype none
module tpw_channel
  import tpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] count_i,
  input wire logic tick_i,
  input wire logic reload_i,
  input wire logic center_i,
  input wire logic pin_level_i,
  input wire logic pin_prev_i,
  input wire logic sc_read_i,
  input wire logic sc_write_i,
  input wire logic hi_write_i,
  input wire logic lo_write_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] sc_o,
  output logic [15:0] value_o,
  output logic out_o,
  output logic drive_o,
  output logic irq_o
);

  logic [7:0] sc_r, sc_nxt;
  logic [15:0] val_r, val_nxt;
  logic [15:0] act_r, act_nxt;
  logic arm_r, arm_nxt;
  logic out_r, out_nxt;
  logic [1:0] mode;
  logic [1:0] edge_sel;
  logic pwm;

  assign mode = sc_r[CH_MODE_HI:CH_MODE_LO];
  assign edge_sel = sc_r[CH_EDGE_HI:CH_EDGE_LO];
  assign pwm = center_i | mode[1];

  always_comb
  begin
    logic rise;
    logic fall;
    logic hit;
    logic evt;
    rise = pin_level_i & ~pin_prev_i;
    fall = ~pin_level_i & pin_prev_i;
    hit = tick_i && (count_i == (pwm ? act_r : val_r));
    evt = 1'b0;
    sc_nxt = sc_r;
    val_nxt = val_r;
    act_nxt = act_r;
    arm_nxt = arm_r;
    out_nxt = out_r;
    if (sc_write_i)
    begin
      sc_nxt[CH_IE_BIT:CH_EDGE_LO] = wdata_i[CH_IE_BIT:CH_EDGE_LO];
      if (arm_r && !wdata_i[CH_FLAG_BIT])
        sc_nxt[CH_FLAG_BIT] = 1'b0;
      arm_nxt = 1'b0;
    end
    if (sc_read_i && sc_r[CH_FLAG_BIT])
      arm_nxt = 1'b1;
    if (hi_write_i)
      val_nxt[15:8] = wdata_i;
    if (lo_write_i)
      val_nxt[7:0] = wdata_i;
    if (pwm)
    begin
      if (reload_i)
        act_nxt = val_r;
      out_nxt = (count_i < act_r) ^ edge_sel[0];
      evt = hit;
    end
    else if (mode == MODE_CAPTURE)
    begin
      if ((edge_sel[0] && rise) || (edge_sel[1] && fall))
      begin
        val_nxt = count_i;
        evt = 1'b1;
      end
    end
    else if (hit)
    begin
      evt = 1'b1;
      unique case (edge_sel)
        2'h0: out_nxt = out_r;
        2'h1: out_nxt = ~out_r;
        2'h2: out_nxt = 1'b0;
        2'h3: out_nxt = 1'b1;
      endcase
    end
    // A new event wins over a clear in the same cycle and restarts the sequence.
    if (evt)
    begin
      sc_nxt[CH_FLAG_BIT] = 1'b1;
      arm_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sc_r <= SC_RESET;
      val_r <= CNT_RESET;
      act_r <= CNT_RESET;
      arm_r <= 1'b0;
      out_r <= 1'b0;
    end
    else
    begin
      sc_r <= sc_nxt;
      val_r <= val_nxt;
      act_r <= act_nxt;
      arm_r <= arm_nxt;
      out_r <= out_nxt;
    end
  end

  assign sc_o = sc_r;
  assign value_o = val_r;
  assign out_o = out_r;
  assign drive_o = (pwm || mode == MODE_COMPARE) && edge_sel != 2'h0;
  assign irq_o = sc_r[CH_FLAG_BIT] & sc_r[CH_IE_BIT];

endmodule : tpw_channel
`default_nettype wire

/* File: core/tpw_timer.sv */
// Two-channel 16-bit timer with PWM, reached over a Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Two channels, each independently capture, compare or edge PWM.
// - Clock select 00 off, 01 bus clock, 10 unused, 11 crystal clock.
// - Crystal selection counts from the 500 kHz crystal-derived clock input.
// - Selected clock passes a prescaler of 1 to 128 before counting.
// - Option bit routes either the pin or slow oscillator to channel 0.
// - Counter counts up normally, up and down in center-aligned PWM.
// - Center-aligned PWM covers all channels and uses buffered values.
// - Modulo sets range; 0x0000 or 0xFFFF means free running.
// - Reading the counter never disturbs counting.
// - Writing either counter byte resets the counter.
// - Capture triggers on rising, falling or any edge.
// - Compare match sets, clears or toggles the output.
// - PWM outputs have selectable polarity.
// - One interrupt per channel plus one for terminal count.
// - Channels optionally drive two shared port pins.
// - Overflow flag sets on wrap to zero, or leaving modulo downward.
// - Flag clears by read while set then writing 0; new overflow restarts.
// - Reading one counter byte latches both until the other is read.
// - Prescale field is a power of two, 000 is 1, 111 is 128.
module tpw_timer
  import tpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic crystal_derived_clock_i,
  input wire logic slow_oscillator_i,
  input wire logic [1:0] shared_port_pin_i,
  output logic [1:0] shared_port_pin_o,
  output logic [1:0] shared_port_pin_oe_n_o,
  output logic ovf_irq_o,
  output logic [1:0] chan_irq_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // power-of-two divisor
  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    ps_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction : ps_mask

  function automatic logic [7:0] pick(input logic [15:0] v, input logic hi);
    pick = hi ? v[15:8] : v[7:0];
  endfunction : pick

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Bits: 0,1 port pins, 2 slow oscillator, 3 crystal clock.
  logic [3:0] s1_r, s2_r, s3_r, lvl_r, prev_r;
  logic [3:0] lvl_nxt;

  always_comb
  begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < 4; i++)
      if (s2_r[i] == s3_r[i])
        lvl_nxt[i] = s2_r[i];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      s3_r <= 4'h0;
      lvl_r <= 4'h0;
      prev_r <= 4'h0;
    end
    else
    begin
      s1_r <= {crystal_derived_clock_i, slow_oscillator_i, shared_port_pin_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      prev_r <= lvl_r;
    end
  end

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [3:0] idx;
  logic mapped;
  logic rd_go;
  logic wr_go;

  assign idx = wb_adr_i[5:2];
  assign mapped = wb_adr_i[7:6] == 2'h0 && idx <= IDX_SOPT;
  // Read side effects act when the request is first seen, so data and latch agree.
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r && mapped;
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_r && mapped && wb_sel_i[0];

  // ************************************************************
  // Counter, prescaler and control
  // ************************************************************
  logic [15:0] cnt_r, cnt_nxt, mod_r, mod_nxt, buf_r, buf_nxt;
  logic [6:0] pre_r, pre_nxt, sc_r, sc_nxt;
  logic [7:0] sopt_r, sopt_nxt;
  tpw_dir_type dir_r, dir_nxt;
  logic ovf_r, ovf_nxt, arm_r, arm_nxt, lat_r, lat_nxt, first_r, first_nxt;
  logic src, tick, wrap, cnt_rd;
  logic [15:0] top;

  assign top = (mod_r == MOD_RESET) ? CNT_MAX : mod_r;
  assign cnt_rd = rd_go && (idx == IDX_CNT_HI || idx == IDX_CNT_LO);

  always_comb
  begin
    unique case (sc_r[SC_CLK_HI:SC_CLK_LO])
      CLK_NONE: src = 1'b0;
      CLK_BUS: src = 1'b1;
      CLK_UNUSED: src = 1'b0;
      CLK_XTAL: src = lvl_r[3] & ~prev_r[3];
    endcase
    // prescaler
    // Only the low bits of the divider are compared, so a smaller divisor takes over at once.
    tick = src && ((pre_r & ps_mask(sc_r[SC_PS_HI:0])) == ps_mask(sc_r[SC_PS_HI:0]));
    pre_nxt = src ? (tick ? PRE_RESET : 7'(pre_r + 7'h01)) : pre_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    wrap = 1'b0;
    if (tick)
    begin
      if (!sc_r[SC_CENTER_BIT])
      begin
        dir_nxt = TPW_UP;
        if (cnt_r == top)
        begin
          cnt_nxt = CNT_RESET;
          wrap = 1'b1;
        end
        else
          cnt_nxt = 16'(cnt_r + 16'h0001);
      end
      else if (dir_r == TPW_UP)
      begin
        if (cnt_r >= top)
        begin
          dir_nxt = TPW_DOWN;
          cnt_nxt = 16'(top - 16'h0001);
          wrap = 1'b1;
        end
        else
          cnt_nxt = 16'(cnt_r + 16'h0001);
      end
      else if (cnt_r == CNT_RESET)
      begin
        dir_nxt = TPW_UP;
        cnt_nxt = 16'h0001;
      end
      else
        cnt_nxt = 16'(cnt_r - 16'h0001);
    end
    if (wr_go && (idx == IDX_CNT_HI || idx == IDX_CNT_LO))
    begin
      cnt_nxt = CNT_RESET;
      dir_nxt = TPW_UP;
      pre_nxt = PRE_RESET;
    end
    mod_nxt = mod_r;
    if (wr_go && idx == IDX_MOD_HI)
      mod_nxt[15:8] = wb_dat_i[7:0];
    if (wr_go && idx == IDX_MOD_LO)
      mod_nxt[7:0] = wb_dat_i[7:0];
    sopt_nxt = (wr_go && idx == IDX_SOPT) ? wb_dat_i[7:0] : sopt_r;
    sc_nxt = (wr_go && idx == IDX_SC) ? wb_dat_i[6:0] : sc_r;
    ovf_nxt = ovf_r;
    arm_nxt = arm_r;
    if (rd_go && idx == IDX_SC && ovf_r)
      arm_nxt = 1'b1;
    if (wr_go && idx == IDX_SC)
    begin
      if (arm_r && !wb_dat_i[SC_OVF_BIT])
        ovf_nxt = 1'b0;
      arm_nxt = 1'b0;
    end
    // overflow sets, winning over a clear
    if (wrap)
    begin
      ovf_nxt = 1'b1;
      arm_nxt = 1'b0;
    end
    lat_nxt = lat_r;
    first_nxt = first_r;
    buf_nxt = buf_r;
    if (cnt_rd)
    begin
      if (!lat_r)
      begin
        lat_nxt = 1'b1;
        first_nxt = idx == IDX_CNT_HI;
        buf_nxt = cnt_r;
      end
      else if (first_r != (idx == IDX_CNT_HI))
        lat_nxt = 1'b0;
    end
    if (wr_go && (idx == IDX_SC || idx == IDX_CNT_HI || idx == IDX_CNT_LO))
      lat_nxt = 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= CNT_RESET;
      mod_r <= MOD_RESET;
      buf_r <= CNT_RESET;
      pre_r <= PRE_RESET;
      sc_r <= SC_RESET[6:0];
      sopt_r <= SOPT_RESET;
      dir_r <= TPW_UP;
      ovf_r <= 1'b0;
      arm_r <= 1'b0;
      lat_r <= 1'b0;
      first_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      mod_r <= mod_nxt;
      buf_r <= buf_nxt;
      pre_r <= pre_nxt;
      sc_r <= sc_nxt;
      sopt_r <= sopt_nxt;
      dir_r <= dir_nxt;
      ovf_r <= ovf_nxt;
      arm_r <= arm_nxt;
      lat_r <= lat_nxt;
      first_r <= first_nxt;
    end
  end

  // ************************************************************
  // Channels
  // ************************************************************
  logic [7:0] ch_sc [2];
  logic [15:0] ch_val [2];
  logic [1:0] ch_out, ch_drive, ch_irq, ch_lvl, ch_prev;

  assign ch_lvl[0] = sopt_r[SOPT_SLOW_OSC_BIT] ? lvl_r[2] : lvl_r[0];
  assign ch_prev[0] = sopt_r[SOPT_SLOW_OSC_BIT] ? prev_r[2] : prev_r[0];
  assign ch_lvl[1] = lvl_r[1];
  assign ch_prev[1] = prev_r[1];

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    localparam logic [3:0] BASE = 4'(IDX_CH0_SC + 4'(3 * c));
    tpw_channel u_ch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .count_i(cnt_r),
      .tick_i(tick),
      .reload_i(wrap),
      .center_i(sc_r[SC_CENTER_BIT]),
      .pin_level_i(ch_lvl[c]),
      .pin_prev_i(ch_prev[c]),
      .sc_read_i(rd_go && idx == BASE),
      .sc_write_i(wr_go && idx == BASE),
      .hi_write_i(wr_go && idx == 4'(BASE + 4'h1)),
      .lo_write_i(wr_go && idx == 4'(BASE + 4'h2)),
      .wdata_i(wb_dat_i[7:0]),
      .sc_o(ch_sc[c]),
      .value_o(ch_val[c]),
      .out_o(ch_out[c]),
      .drive_o(ch_drive[c]),
      .irq_o(ch_irq[c])
    );
  end

  // ************************************************************
  // Read data, pins and interrupts
  // ************************************************************
  logic [1:0] pin_r, pin_nxt, oe_n_r, oe_n_nxt, chirq_r;
  logic ovfirq_r, ovfirq_nxt;

  always_comb
  begin
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    dat_nxt = 32'h0000_0000;
    // reads do not touch the counter
    unique case (idx)
      IDX_SC: dat_nxt[7:0] = {ovf_r, sc_r};
      IDX_CNT_HI: dat_nxt[7:0] = pick(lat_r ? buf_r : cnt_r, 1'b1);
      IDX_CNT_LO: dat_nxt[7:0] = pick(lat_r ? buf_r : cnt_r, 1'b0);
      IDX_MOD_HI: dat_nxt[7:0] = pick(mod_r, 1'b1);
      IDX_MOD_LO: dat_nxt[7:0] = pick(mod_r, 1'b0);
      IDX_CH0_SC: dat_nxt[7:0] = ch_sc[0];
      IDX_CH0_HI: dat_nxt[7:0] = pick(ch_val[0], 1'b1);
      IDX_CH0_LO: dat_nxt[7:0] = pick(ch_val[0], 1'b0);
      IDX_CH1_SC: dat_nxt[7:0] = ch_sc[1];
      IDX_CH1_HI: dat_nxt[7:0] = pick(ch_val[1], 1'b1);
      IDX_CH1_LO: dat_nxt[7:0] = pick(ch_val[1], 1'b0);
      IDX_SOPT: dat_nxt[7:0] = sopt_r;
      default: dat_nxt = 32'h0000_0000;
    endcase
    if (!mapped || !ack_nxt)
      dat_nxt = 32'h0000_0000;
    pin_nxt = ch_out;
    oe_n_nxt = ~(sopt_r[SOPT_PIN0_BIT +: 2] & ch_drive);
    ovfirq_nxt = ovf_nxt & sc_nxt[SC_OVF_IE_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      pin_r <= 2'h0;
      oe_n_r <= 2'h3;
      ovfirq_r <= 1'b0;
      chirq_r <= 2'h0;
    end
    else
    begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      pin_r <= pin_nxt;
      oe_n_r <= oe_n_nxt;
      ovfirq_r <= ovfirq_nxt;
      chirq_r <= ch_irq;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign shared_port_pin_o = pin_r;
  assign shared_port_pin_oe_n_o = oe_n_r;
  assign ovf_irq_o = ovfirq_r;
  assign chan_irq_o = chirq_r;

endmodule : tpw_timer
`default_nettype wire

/* File: testbench/tpw_timer_props.sv */
// Concurrent checks on the timer's bus answers, pin drive and interrupts.
`timescale 1ns/1ps
`default_nettype none
module tpw_timer_props
  import tpw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic crystal_derived_clock_i,
  input wire logic slow_oscillator_i,
  input wire logic [1:0] shared_port_pin_i,
  input wire logic [1:0] shared_port_pin_o,
  input wire logic [1:0] shared_port_pin_oe_n_o,
  input wire logic ovf_irq_o,
  input wire logic [1:0] chan_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Flags and drive enables only drop after software wrote, as the flag and enable are registered.
  sequence s_recent_write;
    $past(wb_stb_i && wb_we_i) || $past(wb_stb_i && wb_we_i, 2) ||
      $past(wb_stb_i && wb_we_i, 3);
  endsequence
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("bus request not answered after one cycle");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_has_request: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_data_byte_wide: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_reset_pins_idle: assert property ($fell(rst_i) |->
    shared_port_pin_oe_n_o == 2'h3 && !ovf_irq_o && chan_irq_o == 2'h0)
    else $error("pins or interrupts active after reset");
  a_ovf_irq_holds: assert property ($fell(ovf_irq_o) |-> s_recent_write)
    else $error("overflow interrupt dropped without a write");
  a_chan_irq_holds: assert property (
    (($past(chan_irq_o) & ~chan_irq_o) != 2'h0) |-> s_recent_write)
    else $error("channel interrupt dropped without a write");
  a_drive_by_write: assert property (!$stable(shared_port_pin_oe_n_o) |-> s_recent_write)
    else $error("pin drive changed without a write");
endmodule : tpw_timer_props
bind tpw_timer tpw_timer_props u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .crystal_derived_clock_i, .slow_oscillator_i,
  .shared_port_pin_i, .shared_port_pin_o, .shared_port_pin_oe_n_o, .ovf_irq_o, .chan_irq_o
);
`default_nettype wire

/* File: testbench/tpw_pins_model.sv */
// Pin-side model: crystal-derived clock, slow oscillator and the two shared pins.
`timescale 1ns/1ps
`default_nettype none
module tpw_pins_model
(
  input wire logic [1:0] pin_cmd_i,
  input wire logic [1:0] drv_i,
  input wire logic [1:0] drv_oe_n_i,
  output logic crystal_clk_o,
  output logic slow_osc_o,
  output logic [1:0] pin_o
);
  // crystal clock source
  // The 13 ns offset keeps its edges away from the bus clock edges, so counts stay exact.
  initial
  begin
    crystal_clk_o = 1'b0;
    #13;
    forever #1000 crystal_clk_o = ~crystal_clk_o;
  end
  initial
  begin
    slow_osc_o = 1'b0;
    forever #3007 slow_osc_o = ~slow_osc_o;
  end
  assign pin_o = (drv_i & ~drv_oe_n_i) | (pin_cmd_i & drv_oe_n_i);
endmodule : tpw_pins_model
`default_nettype wire

/* File: testbench/tpw_timer_tb.sv */
// Self-checking bench for the two-channel timer with PWM.
`timescale 1ns/1ps
`default_nettype none
module tpw_timer_tb
  import tpw_pkg::*;
;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ovf_irq_o, xclk, sosc;
  logic [7:0] wb_adr_i, rd;
  logic [3:0] wb_sel_i, sel_v;
  logic [31:0] wb_dat_i, wb_dat_o, lfsr_r, cyc_n, t1, t2;
  logic [1:0] pin_i, pin_o, oe_n, chan_irq_o, pin_cmd;
  logic [15:0] va, vb;
  int errors, cmp_count;
  tpw_timer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .crystal_derived_clock_i(xclk),
    .slow_oscillator_i(sosc), .shared_port_pin_i(pin_i), .shared_port_pin_o(pin_o),
    .shared_port_pin_oe_n_o(oe_n), .ovf_irq_o(ovf_irq_o), .chan_irq_o(chan_irq_o));
  tpw_pins_model pins (.pin_cmd_i(pin_cmd), .drv_i(pin_o), .drv_oe_n_i(oe_n),
    .crystal_clk_o(xclk), .slow_osc_o(sosc), .pin_o(pin_i));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc_n <= cyc_n + 32'h1;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // ************************************************************
  // Bus cycles and waits, each entered just after a clock edge
  // ************************************************************
  task automatic bus(input logic we, input logic [3:0] idx, input logic [7:0] wd,
    output logic [7:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {2'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= sel_v;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      complete_run();
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, rd);
  endtask : wr
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h0, rd);
    check({24'h0, rd}, {24'h0, exp});
  endtask : rd_chk
  // The gap between the two byte reads lets the live counter move past the latched value.
  task automatic rd_cnt(input logic lo_first, output logic [15:0] v);
    logic [7:0] a;
    logic [7:0] b;
    bus(1'b0, lo_first ? IDX_CNT_LO : IDX_CNT_HI, 8'h0, a);
    repeat (300) @(posedge clk_i);
    bus(1'b0, lo_first ? IDX_CNT_HI : IDX_CNT_LO, 8'h0, b);
    v = lo_first ? {b, a} : {a, b};
  endtask : rd_cnt
  task automatic wait_lvl(input int b, input logic lvl, output logic [31:0] t);
    int n;
    n = 0;
    while ((b == 2 ? ovf_irq_o : pin_o[b]) !== lvl && n < 9000)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 9000)
    begin
      errors++;
      complete_run();
    end
    t = cyc_n;
  endtask : wait_lvl
  task automatic cap(input logic [1:0] e, input logic lvl, input logic exp, input int w);
    bus(1'b0, IDX_CH0_SC, 8'h0, rd);
    wr(IDX_CH0_SC, {2'h1, MODE_CAPTURE, e, 2'h0});
    repeat (3) @(posedge clk_i);
    pin_cmd[0] <= lvl;
    repeat (w) @(posedge clk_i);
    check({31'h0, chan_irq_o[0]}, {31'h0, exp});
  endtask : cap
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {4'h8, 40'h0};
    {wb_sel_i, sel_v, pin_cmd, cyc_n, errors, cmp_count} = {10'h4, 32'h0, 64'h0};
    lfsr_r = 32'h424d;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 13; i++) rd_chk(i[3:0], 8'h00);
    lfsr_r = lfsr_next(lfsr_r);
    wr(IDX_MOD_LO, lfsr_r[7:0]);
    sel_v = 4'h0;
    wr(IDX_MOD_LO, ~lfsr_r[7:0]);
    wr(4'hc, 8'h5a);
    sel_v = 4'h1;
    rd_chk(IDX_MOD_LO, lfsr_r[7:0]);
    rd_chk(4'hc, 8'h00);
    wr(IDX_MOD_LO, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      wr(IDX_SC, {3'h0, CLK_BUS, 3'h0});
      repeat (300) @(posedge clk_i);
      wr(IDX_SC, {3'h0, k == 0 ? CLK_NONE : CLK_UNUSED, 3'h0});
      rd_cnt(1'b0, va);
      repeat (600) @(posedge clk_i);
      rd_cnt(1'b1, vb);
      check({16'h0, vb}, {16'h0, va});
      lfsr_r = lfsr_next(lfsr_r);
      wr(k == 0 ? IDX_CNT_HI : IDX_CNT_LO, lfsr_r[7:0]);
      rd_cnt(1'b0, vb);
      check({16'h0, vb}, 32'h0);
    end
    for (int p = 0; p < 9; p++)
    begin
      wr(IDX_SC, {3'h0, p == 8 ? CLK_XTAL : CLK_BUS, p == 8 ? 3'h0 : p[2:0]});
      t1 = cyc_n;
      rd_cnt(1'b0, va);
      // The bus-clock window is a multiple of every divisor, so tick counts are exact.
      repeat (t1 + (p == 8 ? 4000 : 4096) - cyc_n) @(posedge clk_i);
      rd_cnt(p[0], vb);
      check(32'(16'(vb - va)), p == 8 ? 100 : 4096 >> p);
    end
    wr(IDX_MOD_LO, 8'h10);
    // A counter already past the new modulo would run on to 0xffff first.
    wr(IDX_CNT_LO, 8'h00);
    for (int c = 0; c < 2; c++)
    begin
      wr(IDX_SC, {2'h1, c[0], CLK_BUS, 3'h7});
      bus(1'b0, IDX_SC, 8'h0, rd);
      wr(IDX_SC, {2'h1, c[0], CLK_BUS, 3'h7});
      repeat (3) @(posedge clk_i);
      wait_lvl(2, 1'b1, t1);
      wr(IDX_SC, {2'h1, c[0], CLK_BUS, 3'h7});
      repeat (3) @(posedge clk_i);
      check({31'h0, ovf_irq_o}, 32'h1);
      rd_chk(IDX_SC, {3'h6 | c[0], CLK_BUS, 3'h7});
      wr(IDX_SC, {2'h1, c[0], CLK_BUS, 3'h7});
      repeat (3) @(posedge clk_i);
      check({31'h0, ovf_irq_o}, 32'h0);
      wait_lvl(2, 1'b1, t2);
      check(t2 - t1, c == 1 ? 32'd4096 : 32'd2176);
    end
    wr(IDX_SC, {3'h0, CLK_BUS, 3'h7});
    wr(IDX_SOPT, 8'h06);
    wr(IDX_CH0_LO, 8'h08);
    wr(IDX_CH0_SC, 8'h14);
    wr(IDX_CH1_LO, 8'h04);
    wr(IDX_CH1_SC, 8'h28);
    repeat (3) @(posedge clk_i);
    check({30'h0, oe_n}, 32'h0);
    wait_lvl(0, 1'b1, t1);
    wait_lvl(0, 1'b0, t2);
    check(t2 - t1, 32'd2176);
    wait_lvl(1, 1'b0, t1);
    wait_lvl(1, 1'b1, t1);
    wait_lvl(1, 1'b0, t2);
    check(t2 - t1, 32'd512);
    wr(IDX_CH1_SC, 8'h64);
    wait_lvl(1, 1'b1, t1);
    wait_lvl(1, 1'b0, t1);
    wait_lvl(1, 1'b1, t2);
    check(t2 - t1, 32'd512);
    check({31'h0, chan_irq_o[1]}, 32'h1);
    wr(IDX_SOPT, 8'h00);
    cap(2'h1, 1'b1, 1'b1, 12);
    cap(2'h1, 1'b0, 1'b0, 12);
    cap(2'h2, 1'b1, 1'b0, 12);
    cap(2'h2, 1'b0, 1'b1, 12);
    cap(2'h3, 1'b1, 1'b1, 12);
    cap(2'h3, 1'b0, 1'b1, 12);
    wr(IDX_SOPT, 8'h01);
    cap(2'h3, 1'b0, 1'b1, 160);
    complete_run();
  end
  initial
  begin
    repeat (100000) @(posedge clk_i);
    errors++;
    complete_run();
  end
endmodule : tpw_timer_tb
`default_nettype wire
